// ===== testbench/ppc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module ppc_top_tb;
	import ppc_pkg::*;
	logic mclk_i = 0, arst_n_i = 0, wr = 0, rd = 0, start = 0, sat = 0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, ma = 8'h00, mb = 8'h20;
	logic [7:0] m6 = 8'h00;
	logic emit, done, auto_on;
	logic [6:0] sent;
	logic [9:0] code;
	int n_mismatch = 0, num_checks = 0, seed = 32'he5de85e0, i;
	ppc_top i_ppc_top (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_rdata_o(rdata), .cycle_start_i(start),
		.near_sat_i(sat), .emitter_o(emit), .cycle_done_o(done),
		.pulses_sent_o(sent), .pulse_width_code_o(code),
		.auto_pulse_control_o(auto_on));
	initial forever #12.5 mclk_i = ~mclk_i;
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	// Model follows every write, read-only places keep their codes
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		wr = 1; addr = a; wd = d;
		@(negedge mclk_i);
		wr = 0;
		if (a == `PPC_OFS_CFG_A) ma = d;
		if (a == `PPC_OFS_CFG_B) mb = d;
		if (a == `PPC_OFS_CFG_SIX) m6 = d;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		logic [7:0] e;
		e = 8'h00;
		if (a == `PPC_OFS_CFG_A) e = ma;
		if (a == `PPC_OFS_CFG_B) e = mb;
		if (a == `PPC_OFS_REV) e = {3'h0, `PPC_FUNC_CODE, `PPC_REV_CODE};
		if (a == `PPC_OFS_PART) e = `PPC_PART_CODE;
		if (a == `PPC_OFS_CFG_SIX) e = m6;
		@(negedge mclk_i);
		rd = 1; addr = a;
		@(negedge mclk_i);
		rd = 0;
		`CHK(rdata, e)
	endtask : rd_reg
	task automatic run_cycle(input logic s);
		int np, nh, k, e;
		logic pv;
		np = 0; nh = 0; pv = 0; sat = s;
		// Fixed mode ignores near-saturation, auto mode stops after one
		e = (m6[6] || !s) ? ma[5:0] + 1 : 1;
		@(negedge mclk_i);
		start = 1;
		@(negedge mclk_i);
		start = 0;
		for (k = 0; k < 20000 && done !== 1'b1; k++) begin
			if (emit === 1'b1 && !pv) np++;
			if (emit === 1'b1) nh++;
			pv = emit;
			@(negedge mclk_i);
		end
		`CHK(done, 1'b1)
		`CHK(sent, 7'(e))
		`CHK(np, e)
		`CHK(nh, e * (int'({ma[7:6], mb}) + 2) * 40)
		sat = 0;
	endtask : run_cycle
	initial begin
		repeat (8) @(negedge mclk_i);
		arst_n_i = 1;
		`CHK(code, 10'h020)
		`CHK(auto_on, 1'b1)
		for (i = 8'h8f; i <= 8'h94; i++) rd_reg(8'(i));
		wr_reg(`PPC_OFS_REV, 8'($random(seed)));
		wr_reg(`PPC_OFS_PART, 8'($random(seed)));
		rd_reg(`PPC_OFS_REV);
		rd_reg(`PPC_OFS_PART);
		$display("register reset and identity test done");
		for (i = 0; i < 6; i++) begin
			wr_reg(`PPC_OFS_CFG_A, 8'($random(seed)));
			wr_reg(`PPC_OFS_CFG_B, 8'($random(seed)));
			`CHK(code, {ma[7:6], mb})
			rd_reg(`PPC_OFS_CFG_A);
			rd_reg(`PPC_OFS_CFG_B);
		end
		$display("pulse length field test done");
		// Short legal length keeps each cycle brief
		wr_reg(`PPC_OFS_CFG_B, 8'h0f);
		for (i = 0; i < 4; i++) begin
			wr_reg(`PPC_OFS_CFG_A, 8'($random(seed)) & 8'h03);
			wr_reg(`PPC_OFS_CFG_SIX, {1'b0, i[1], 6'h00});
			`CHK(auto_on, !i[1])
			rd_reg(`PPC_OFS_CFG_SIX);
			run_cycle(!i[0]);
		end
		$display("proximity cycle test done");
		conclude();
	end
	initial begin
		repeat (60000) @(posedge mclk_i);
		n_mismatch++;
		conclude();
	end
endmodule : ppc_top_tb
`default_nettype wire

// ===== verilog/ppc_cfg.svh
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
`define PPC_OFS_CFG_A 8'h8f
`define PPC_OFS_CFG_B 8'h90
`define PPC_OFS_REV 8'h91
`define PPC_OFS_PART 8'h92
`define PPC_OFS_CFG_SIX 8'h93
`define PPC_RST_CFG_A 8'h00
`define PPC_RST_CFG_B 8'h20
`define PPC_RST_CFG_SIX 8'h00
`define PPC_AUTO_OFF_BIT 6
// Identity codes: arbitrary neutral values
`define PPC_FUNC_CODE 2'h1
`define PPC_REV_CODE 3'h2
`define PPC_PART_CODE 8'h5a
`define PPC_PULSE_US_ADD 10'h002
`define PPC_CYC_PER_US 6'h28
`define PPC_MIN_PULSE_US 11'h011
`endif

// ===== verilog/ppc_pkg.sv
`default_nettype none
package ppc_pkg;
	typedef enum logic [1:0] {
		PPC_IDLE = 2'b00,
		PPC_PULSE = 2'b01,
		PPC_GAP = 2'b10
	} ppc_state_t;
endpackage : ppc_pkg
`default_nettype wire

// ===== verilog/ppc_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
// Times one emitter pulse: (code + 2) microseconds at 40 clocks per us
module ppc_pulse_timer (
	input wire logic mclk_i, // Clock
	input wire logic arst_n_i, // Async reset, low
	input wire logic start_i, // Start one pulse
	input wire logic [9:0] width_code_i, // Pulse length code
	output logic busy_o // Pulse in progress
);
	logic [10:0] us_q;
	logic [5:0] sub_q;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			us_q <= 11'h000;
			sub_q <= 6'h00;
		end else if (start_i && us_q == 11'h000) begin
			us_q <= {1'b0, width_code_i} + {1'b0, `PPC_PULSE_US_ADD};
			sub_q <= `PPC_CYC_PER_US - 6'h01;
		end else if (us_q != 11'h000) begin
			if (sub_q == 6'h00) begin
				us_q <= us_q - 11'h001;
				sub_q <= `PPC_CYC_PER_US - 6'h01;
			end else begin
				sub_q <= sub_q - 6'h01;
			end
		end
	end
	assign busy_o = (us_q != 11'h000);
endmodule : ppc_pulse_timer
`default_nettype wire

// ===== verilog/ppc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
module ppc_top
	import ppc_pkg::*;
(
	input wire logic mclk_i, // 40 MHz clock
	input wire logic arst_n_i, // Async reset, low
	input wire logic reg_wr_i, // Register write strobe
	input wire logic reg_rd_i, // Register read strobe
	input wire logic [7:0] reg_addr_i, // Register address
	input wire logic [7:0] reg_wdata_i, // Write data
	output logic [7:0] reg_rdata_o, // Read data, registered
	input wire logic cycle_start_i, // Start a proximity cycle
	input wire logic near_sat_i, // Near-saturation from front end
	output logic emitter_o, // Emitter drive
	output logic cycle_done_o, // Cycle finished, one pulse
	output logic [6:0] pulses_sent_o, // Pulses in last cycle
	output logic [9:0] pulse_width_code_o, // Current length code
	output logic auto_pulse_control_o // Automatic control active
);
	logic [7:0] cfg_a_q;
	logic [7:0] cfg_b_q;
	logic [7:0] cfg_six_q;
	logic [7:0] rdata_q;
	logic [6:0] cnt_q;
	logic [6:0] sent_q;
	logic done_q;
	logic busy;
	logic start_pulse;
	logic stop_now;
	logic [6:0] max_pulses;
	ppc_state_t state_q;

	function automatic logic [7:0] reg_read(input logic [7:0] a,
		input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] c6);
		case (a)
			`PPC_OFS_CFG_A: reg_read = ca;
			`PPC_OFS_CFG_B: reg_read = cb;
			`PPC_OFS_REV: reg_read = {3'h0, `PPC_FUNC_CODE, `PPC_REV_CODE};
			`PPC_OFS_PART: reg_read = `PPC_PART_CODE;
			`PPC_OFS_CFG_SIX: reg_read = c6;
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// Revision and part codes have no storage, so writes there fall away
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_a_q <= `PPC_RST_CFG_A;
			cfg_b_q <= `PPC_RST_CFG_B;
			cfg_six_q <= `PPC_RST_CFG_SIX;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `PPC_OFS_CFG_A)
				cfg_a_q <= reg_wdata_i;
			if (reg_addr_i == `PPC_OFS_CFG_B)
				cfg_b_q <= reg_wdata_i;
			if (reg_addr_i == `PPC_OFS_CFG_SIX)
				cfg_six_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_q <= reg_read(reg_addr_i, cfg_a_q, cfg_b_q,
				cfg_six_q);
		end
	end
	assign reg_rdata_o = rdata_q;

	assign pulse_width_code_o = {cfg_a_q[7:6], cfg_b_q};
	assign max_pulses = {1'b0, cfg_a_q[5:0]} + 7'h01;
	assign auto_pulse_control_o = !cfg_six_q[`PPC_AUTO_OFF_BIT];
	// Saturation only cuts a cycle short in automatic mode
	assign stop_now = (cnt_q >= max_pulses) ||
		(auto_pulse_control_o && near_sat_i);

	ppc_pulse_timer u_timer (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.start_i(start_pulse),
		.width_code_i(pulse_width_code_o),
		.busy_o(busy)
	);

	assign start_pulse = (state_q == PPC_IDLE && cycle_start_i) ||
		(state_q == PPC_GAP && !busy && !stop_now);

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= PPC_IDLE;
			cnt_q <= 7'h00;
			sent_q <= 7'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				PPC_IDLE: begin
					if (cycle_start_i) begin
						cnt_q <= 7'h01;
						state_q <= PPC_PULSE;
					end
				end
				PPC_PULSE: begin
					state_q <= PPC_GAP;
				end
				PPC_GAP: begin
					// Pulse ends before the next decision, one idle clock min
					if (!busy) begin
						if (stop_now) begin
							sent_q <= cnt_q;
							done_q <= 1'b1;
							state_q <= PPC_IDLE;
						end else begin
							cnt_q <= cnt_q + 7'h01;
							state_q <= PPC_PULSE;
						end
					end
				end
				default: state_q <= PPC_IDLE;
			endcase
		end
	end
	assign emitter_o = busy;
	assign cycle_done_o = done_q;
	assign pulses_sent_o = sent_q;

	// Assertion helper only: measures each pulse against the code latched
	// at its start, since a config write may land in mid-pulse
	logic [15:0] span_q;
	logic [9:0] span_code_q;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			span_code_q <= 10'h000;
		end else if (start_pulse && !busy) begin
			span_code_q <= pulse_width_code_o;
		end
	end
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			span_q <= 16'h0000;
		end else if (busy) begin
			span_q <= span_q + 16'h0001;
		end else begin
			span_q <= 16'h0000;
		end
	end

	a_fixed_count: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(done_q && cfg_six_q[`PPC_AUTO_OFF_BIT] &&
		!$past(reg_wr_i)) |->
		sent_q == max_pulses)
		else $error("fixed mode pulse count wrong");
	a_count_limit: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		done_q |-> (sent_q <= max_pulses || $past(reg_wr_i)))
		else $error("pulse count above maximum");
	a_sat_stop: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(state_q == PPC_GAP && !busy && near_sat_i &&
		auto_pulse_control_o) |=> state_q == PPC_IDLE && done_q)
		else $error("saturation did not end cycle");
	a_fixed_more: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(state_q == PPC_GAP && !busy && !auto_pulse_control_o &&
		cnt_q < max_pulses) |=> state_q == PPC_PULSE && busy)
		else $error("fixed mode stopped early");
	a_one_gap: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		$fell(busy) |=> (busy || done_q))
		else $error("gap after pulse not one clock");
	a_done_single: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		done_q |=> !done_q)
		else $error("cycle done longer than one clock");
	a_idle_dark: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		state_q == PPC_IDLE |-> !busy)
		else $error("emitter on while idle");

	a_width_map: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		pulse_width_code_o[7:0] == cfg_b_q &&
		pulse_width_code_o[9:8] == cfg_a_q[7:6])
		else $error("pulse width code misassembled");
	a_pulse_len: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(state_q == PPC_IDLE && cycle_start_i && !reg_wr_i &&
		pulse_width_code_o == 10'h000) |=> busy [*8] ##73 !busy)
		else $error("pulse length not code plus two us");
	// Any legal code gives at least two microseconds of drive
	a_pulse_min: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(state_q == PPC_IDLE && cycle_start_i) |=> busy [*8] ##72 busy)
		else $error("pulse shorter than two us");
	a_pulse_span: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		$fell(busy) |-> span_q == (16'(span_code_q) +
		16'(`PPC_PULSE_US_ADD)) * 16'(`PPC_CYC_PER_US))
		else $error("pulse span not code plus two us");

	a_cfg_a_write: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(reg_wr_i && reg_addr_i == `PPC_OFS_CFG_A) |=>
		cfg_a_q == $past(reg_wdata_i))
		else $error("pulse config a write lost");
	a_cfg_b_write: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(reg_wr_i && reg_addr_i == `PPC_OFS_CFG_B) |=>
		cfg_b_q == $past(reg_wdata_i))
		else $error("pulse config b write lost");
	a_six_read: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(reg_rd_i && reg_addr_i == `PPC_OFS_CFG_SIX) |=>
		reg_rdata_o == $past(cfg_six_q))
		else $error("config six read wrong");
	a_ro_regs: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(reg_rd_i && reg_addr_i == `PPC_OFS_PART) |=>
		reg_rdata_o == `PPC_PART_CODE)
		else $error("part code not fixed");
	a_rev_read: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(reg_rd_i && reg_addr_i == `PPC_OFS_REV) |=>
		reg_rdata_o == {3'h0, `PPC_FUNC_CODE, `PPC_REV_CODE})
		else $error("revision code not fixed");
	a_unmapped_read: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(reg_rd_i && reg_addr_i != `PPC_OFS_CFG_A &&
		reg_addr_i != `PPC_OFS_CFG_B && reg_addr_i != `PPC_OFS_REV &&
		reg_addr_i != `PPC_OFS_PART && reg_addr_i != `PPC_OFS_CFG_SIX)
		|=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_b_reset: assert property (
		@(posedge mclk_i)
		$rose(arst_n_i) |-> cfg_b_q == `PPC_RST_CFG_B)
		else $error("length low byte reset wrong");
endmodule : ppc_top
`default_nettype wire
